/* File: hdl/apl_line_if.sv */
// ami pcm line interface: rails, clock recovery, loopbacks, axi4-lite regs
`timescale 1ns/1ns
// Contract
// - positive line pulse raises positive receive rail
// - negative line pulse raises negative receive rail
// - recovered clock latches rails and goes out
// - loss of signal when peak below threshold
// - transmit only while transmit clock is low
// - both transmit rails high inhibit the driver
// - positive rail drives positive line, negative likewise
// - line loopback feeds receive data to transmitter
// - local loopback routes transmit inputs to receive outputs
// - hdb3 substitutions pass through unaltered
// - nominal line rate 2048 kbit/s both ways
module apl_line_if import apl_pkg::*; #(
  parameter logic [31:0] INC = NCO_INC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [4:0] s_awaddr_in,
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  output logic [1:0] s_bresp_out,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [4:0] s_araddr_in,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  input wire logic line_pos_det_in,
  input wire logic line_neg_det_in,
  input wire logic [7:0] peak_level_in,
  input wire logic xmit_positive_rail_in,
  input wire logic xmit_negative_rail_in,
  input wire logic xmit_clock_input_in,
  input wire logic line_loopback_n_in,
  input wire logic local_loopback_n_in,
  output logic recv_positive_rail_out,
  output logic recv_negative_rail_out,
  output logic recovered_clock_out,
  output logic loss_of_signal_out,
  output logic line_drive_positive_out,
  output logic line_drive_negative_out,
  output logic irq_out
);
  localparam int AST_BIT_MAX = 60;

  logic rclk;
  logic rx_pos;
  logic rx_neg;
  logic rx_mark;
  logic tx_pos;
  logic tx_neg;
  logic tx_clk;
  logic tx_inh_q;
  logic los_q;
  logic [7:0] los_thr_q;
  logic [NUM_EV-1:0] irq_stat_q;
  logic [NUM_EV-1:0] irq_mask_q;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] w1c;
  logic aw_full_q;
  logic w_full_q;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] wmask;
  logic do_wr;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;
  logic rd_hit;

  // receive path: nco runs at the nominal line rate
  apl_clk_recover #(
    .INC(INC)
  ) u_rec (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pos_det_in(line_pos_det_in),
    .neg_det_in(line_neg_det_in),
    .rclk_out(rclk),
    .pos_out(rx_pos),
    .neg_out(rx_neg),
    .mark_out(rx_mark)
  );

  // loss of signal from the peak level; registered to filter glitches
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      los_q <= 1'b0;
    end else begin
      los_q <= peak_level_in < los_thr_q;
    end
  end
  assign loss_of_signal_out = los_q;

  // loopback multiplexer, pure gates so selects act at once
  assign tx_pos = line_loopback_n_in ? xmit_positive_rail_in : rx_pos;
  assign tx_neg = line_loopback_n_in ? xmit_negative_rail_in : rx_neg;
  assign tx_clk = line_loopback_n_in ? xmit_clock_input_in : rclk;
  assign recv_positive_rail_out = local_loopback_n_in ? rx_pos : xmit_positive_rail_in;
  assign recv_negative_rail_out = local_loopback_n_in ? rx_neg : xmit_negative_rail_in;
  assign recovered_clock_out = local_loopback_n_in ? rclk : xmit_clock_input_in;

  // driver: pulse width follows the low phase of the transmit clock
  // rails pass as given, so hdb3 violations go out unchanged
  assign line_drive_positive_out = ~tx_inh_q & ~tx_clk & tx_pos & ~tx_neg;
  assign line_drive_negative_out = ~tx_inh_q & ~tx_clk & tx_neg & ~tx_pos;

  // sticky events; a new event beats a write-one-to-clear in the same cycle
  assign ev[EV_LOS_SET] = (peak_level_in < los_thr_q) & ~los_q;
  assign ev[EV_LOS_CLR] = ~(peak_level_in < los_thr_q) & los_q;
  assign ev[EV_MARK] = rx_mark;
  assign w1c = (do_wr && awaddr_q == OFF_IRQ_STAT && wstrb_q[0])
             ? wdata_q[NUM_EV-1:0] : '0;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
    end
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // write channel: address and data taken in either order, then answered
  assign s_awready_out = ~aw_full_q & ~bvalid_q;
  assign s_wready_out = ~w_full_q & ~bvalid_q;
  assign do_wr = aw_full_q & w_full_q;
  assign wmask = wmask_of(s_wstrb_in);
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_awvalid_in && s_awready_out) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_awaddr_in;
      end else if (do_wr) begin
        aw_full_q <= 1'b0;
      end
      if (s_wvalid_in && s_wready_out) begin
        w_full_q <= 1'b1;
        wdata_q <= s_wdata_in & wmask;
        wstrb_q <= s_wstrb_in;
      end else if (do_wr) begin
        w_full_q <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] wmask_of(input logic [3:0] s);
    wmask_of = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // write response; unmapped or read-only offsets answer slverr
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q == OFF_CTRL || awaddr_q == OFF_IRQ_STAT ||
                  awaddr_q == OFF_IRQ_MASK || awaddr_q == OFF_LOS_THR)
                 ? RESP_OKAY : RESP_SLVERR;
    end else if (s_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_bvalid_out = bvalid_q;
  assign s_bresp_out = bresp_q;

  // control registers, each byte lane honoured by its strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tx_inh_q <= 1'b0;
      irq_mask_q <= IRQ_MASK_RST;
      los_thr_q <= LOS_THR_RST;
    end else if (do_wr && wstrb_q[0]) begin
      if (awaddr_q == OFF_CTRL) begin
        tx_inh_q <= wdata_q[CTRL_TX_INH];
      end
      if (awaddr_q == OFF_IRQ_MASK) begin
        irq_mask_q <= wdata_q[NUM_EV-1:0];
      end
      if (awaddr_q == OFF_LOS_THR) begin
        los_thr_q <= wdata_q[7:0];
      end
    end
  end

  // read decode; status shows live receive and loopback state
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_araddr_in)
      OFF_CTRL: rd_word[CTRL_TX_INH] = tx_inh_q;
      OFF_STAT: begin
        rd_word[STAT_LOS] = los_q;
        rd_word[STAT_RCLK] = rclk;
        rd_word[STAT_LINE_LB] = ~line_loopback_n_in;
        rd_word[STAT_LOCAL_LB] = ~local_loopback_n_in;
      end
      OFF_IRQ_STAT: rd_word[NUM_EV-1:0] = irq_stat_q;
      OFF_IRQ_MASK: rd_word[NUM_EV-1:0] = irq_mask_q;
      OFF_LOS_THR: rd_word[7:0] = los_thr_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: one read at a time, data held until rready
  assign s_arready_out = ~rvalid_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_arvalid_in && s_arready_out) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_rvalid_out = rvalid_q;
  assign s_rdata_out = rdata_q;
  assign s_rresp_out = rresp_q;

  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  AST_RX_POS: assert property (
    $rose(line_pos_det_in) && !line_neg_det_in |-> ##[1:AST_BIT_MAX] rx_pos)
    else $error("positive mark not latched");
  AST_RX_NEG: assert property (
    $rose(line_neg_det_in) && !line_pos_det_in |-> ##[1:AST_BIT_MAX] rx_neg)
    else $error("negative mark not latched");
  AST_RX_LATCH: assert property (
    $changed(rx_pos) || $changed(rx_neg) |-> $fell(rclk))
    else $error("receive rails moved off the recovered clock edge");
  AST_RCLK_OUT: assert property (
    local_loopback_n_in |-> recovered_clock_out == rclk)
    else $error("recovered clock not driven out");
  AST_LOS: assert property (
    peak_level_in < los_thr_q |=> loss_of_signal_out)
    else $error("loss of signal not raised");
  AST_TX_LOW: assert property (
    tx_clk |-> !line_drive_positive_out && !line_drive_negative_out)
    else $error("line driven while transmit clock high");
  AST_TX_BOTH: assert property (
    tx_pos && tx_neg |-> !line_drive_positive_out && !line_drive_negative_out)
    else $error("driver not inhibited on both rails");
  AST_TX_DRV: assert property (
    !tx_clk && !tx_inh_q && (tx_pos ^ tx_neg)
    |-> line_drive_positive_out == tx_pos && line_drive_negative_out == tx_neg)
    else $error("rail not driven to its line output");
  AST_LINE_LB: assert property (
    !line_loopback_n_in && local_loopback_n_in
    |-> line_drive_negative_out == (!tx_inh_q && !rclk && rx_neg && !rx_pos)
        && recv_negative_rail_out == rx_neg)
    else $error("line loopback path wrong");
  AST_LOCAL_LB: assert property (
    !local_loopback_n_in |-> recv_positive_rail_out == xmit_positive_rail_in
        && recovered_clock_out == xmit_clock_input_in)
    else $error("local loopback path wrong");
  AST_IRQ_LOS: assert property (
    $rose(loss_of_signal_out) && irq_mask_q[EV_LOS_SET] |-> irq_out)
    else $error("loss of signal interrupt missing");
endmodule

/* File: include/apl_pkg.sv */
// constants shared by the ami pcm line interface block
package apl_pkg;
  // timing: line rate and system clock, nco step derived from both
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned LINE_BPS = 64'd2_048_000;
  localparam logic [31:0] NCO_INC = 32'((LINE_BPS << 32) / CLK_HZ);
  localparam logic [31:0] NCO_ALIGN = 32'h0000_0000;
  localparam int unsigned BIT_CYC = 32'(CLK_HZ / LINE_BPS);
  // register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h0c;
  localparam logic [4:0] OFF_LOS_THR = 5'h10;
  // reset values
  localparam logic [7:0] LOS_THR_RST = 8'h40;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // field positions
  localparam int CTRL_TX_INH = 0;
  localparam int STAT_LOS = 0;
  localparam int STAT_RCLK = 1;
  localparam int STAT_LINE_LB = 2;
  localparam int STAT_LOCAL_LB = 3;
  localparam int EV_LOS_SET = 0;
  localparam int EV_LOS_CLR = 1;
  localparam int EV_MARK = 2;
  localparam int NUM_EV = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/apl_clk_recover.sv */
// clock recovery nco and receive rail output latches
`timescale 1ns/1ns
module apl_clk_recover import apl_pkg::*; #(
  parameter logic [31:0] INC = NCO_INC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic pos_det_in,
  input wire logic neg_det_in,
  output logic rclk_out,
  output logic pos_out,
  output logic neg_out,
  output logic mark_out
);
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic prev_q;
  logic seen_pos_q;
  logic seen_neg_q;
  logic wrap;
  logic pulse_edge;

  // a step of half the range or more would alias the recovered clock
  if (INC == 32'h0000_0000 || INC[31]) begin : g_bad_inc
    $error("apl_clk_recover: INC out of range");
  end

  // phase restarts at each mark edge, so one bit ends one period later
  assign pulse_edge = (pos_det_in | neg_det_in) & ~prev_q;
  assign acc_d = pulse_edge ? NCO_ALIGN : acc_q + INC;
  assign wrap = acc_q[31] & ~acc_d[31];
  assign rclk_out = acc_q[31];

  // nco accumulator, its msb is the recovered clock
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      acc_q <= 32'h0000_0000;
      prev_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      prev_q <= pos_det_in | neg_det_in;
    end
  end

  // marks seen in the bit; a mark in the capture cycle is kept (set wins)
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      seen_pos_q <= 1'b0;
      seen_neg_q <= 1'b0;
    end else begin
      seen_pos_q <= pos_det_in | (seen_pos_q & ~wrap);
      seen_neg_q <= neg_det_in | (seen_neg_q & ~wrap);
    end
  end

  // output latches strobed by the recovered clock; no code rule applied
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pos_out <= 1'b0;
      neg_out <= 1'b0;
      mark_out <= 1'b0;
    end else begin
      mark_out <= wrap & (seen_pos_q | seen_neg_q);
      if (wrap) begin
        pos_out <= seen_pos_q;
        neg_out <= seen_neg_q;
      end
    end
  end
endmodule

/* File: sim/apl_line_model.sv */
// behavioural line: ami pulses toward the receive comparators
`timescale 1ns/1ns
module apl_line_model (
  input wire logic mclk_in,
  input wire logic send_in,
  input wire logic pol_in,
  input wire logic [5:0] width_in,
  output logic pos_det_out,
  output logic neg_det_out
);
  logic [5:0] left_q = '0;
  logic pol_q = 1'b0;
  // one pulse per request; a wider pulse models a slow, sloppy line
  always_ff @(posedge mclk_in) begin
    if (send_in && left_q == 6'd0) begin
      left_q <= width_in;
      pol_q <= pol_in;
    end else if (left_q != 6'd0) begin
      left_q <= left_q - 6'd1;
    end
  end
  // comparators rest low between marks, never both at once
  assign pos_det_out = (left_q != 6'd0) && pol_q;
  assign neg_det_out = (left_q != 6'd0) && !pol_q;
endmodule

/* File: sim/ami_pcm_line_interface_test.sv */
// self-checking bench for the ami pcm line interface block
`timescale 1ns/1ns
module ami_pcm_line_interface_test;
  import apl_pkg::*;
  logic mclk_in = 0;
  logic rst_in = 1;
  logic [4:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic tp = 0, tn = 0, tclk = 1, line_n = 1, local_n = 1, send = 0, pol = 0;
  logic [7:0] peak = 8'h80;
  logic [5:0] width = 6'd24;
  logic pdet, ndet, rxp, rxn, rclk, los, dp, dn, irq, seen;
  logic [31:0] r = 32'h0000_b1d2;
  int n_errors = 0, n_compared = 0, cyc = 0;
  logic exp_q[$];
  logic [4:0] ra[4] = '{OFF_CTRL, OFF_IRQ_MASK, OFF_LOS_THR, 5'h14};
  logic [31:0] rv[4] = '{32'h0, 32'(IRQ_MASK_RST), 32'(LOS_THR_RST), 32'h0};
  logic [1:0] rr[4] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
  logic [7:0] pk[5] = '{8'h80, 8'h40, 8'h3f, 8'h00, 8'h41};
  logic pl[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  apl_line_if dut (.mclk_in(mclk_in), .rst_in(rst_in), .s_awaddr_in(awaddr),
    .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata),
    .s_wstrb_in(4'hf), .s_wvalid_in(wvalid), .s_wready_out(wready),
    .s_bresp_out(bresp), .s_bvalid_out(bvalid), .s_bready_in(bready),
    .s_araddr_in(araddr), .s_arvalid_in(arvalid), .s_arready_out(arready),
    .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid),
    .s_rready_in(rready), .line_pos_det_in(pdet), .line_neg_det_in(ndet),
    .peak_level_in(peak), .xmit_positive_rail_in(tp), .xmit_negative_rail_in(tn),
    .xmit_clock_input_in(tclk), .line_loopback_n_in(line_n),
    .local_loopback_n_in(local_n), .recv_positive_rail_out(rxp),
    .recv_negative_rail_out(rxn), .recovered_clock_out(rclk),
    .loss_of_signal_out(los), .line_drive_positive_out(dp),
    .line_drive_negative_out(dn), .irq_out(irq));

  apl_line_model line (.mclk_in(mclk_in), .send_in(send), .pol_in(pol),
    .width_in(width), .pos_det_out(pdet), .neg_det_out(ndet));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // handshakes are judged at the falling edge, released after the rising one
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic done, a_t, w_t;
    @(posedge mclk_in);
    done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(negedge mclk_in);
      a_t = awready;
      w_t = wready;
      done = bvalid;
      rs = bresp;
      @(posedge mclk_in);
      if (a_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
    end
    bready <= 0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic done, a_t;
    @(posedge mclk_in);
    done = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(negedge mclk_in);
      a_t = arready;
      done = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge mclk_in);
      if (a_t) arvalid <= 0;
    end
    rready <= 0;
  endtask

  // one mark from the line; rails must follow its polarity untouched
  task automatic rx_mark(input logic p);
    int k;
    exp_q.push_back(p);
    pol <= p;
    send <= 1;
    @(posedge mclk_in);
    send <= 0;
    k = 0;
    do begin
      @(negedge mclk_in);
      k++;
    end while (!(rxp | rxn) && k < 70);
    chk(32'({rxp, rxn, rclk}), 32'({exp_q[0], !exp_q[0], 1'b0}));
    void'(exp_q.pop_front());
    repeat (100) @(posedge mclk_in);
    chk(32'({rxp, rxn}), 32'h0);
  endtask

  // hang guard, far beyond the roughly 1200 cycles the run needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    rst_in <= 0;
    @(posedge mclk_in);
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], v, resp);
      chk(v, rv[i]);
      chk(32'(resp), 32'(rr[i]));
    end
    wr(OFF_STAT, 32'h1, resp);
    chk(32'(resp), 32'(RESP_SLVERR));
    // random rails, clock and local loopback; drivers are combinational
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      tp <= r[0];
      tn <= r[1];
      tclk <= r[2];
      local_n <= r[3];
      @(negedge mclk_in);
      chk(32'({dp, dn}), 32'({!tclk & tp & !tn, !tclk & tn & !tp}));
      if (!local_n) chk(32'({rxp, rxn, rclk}), 32'({tp, tn, tclk}));
      @(posedge mclk_in);
    end
    local_n <= 1;
    wr(OFF_CTRL, 32'h1, resp);
    tp <= 1;
    tn <= 0;
    tclk <= 0;
    @(negedge mclk_in);
    chk(32'(dp), 32'h0);
    wr(OFF_CTRL, 32'h0, resp);
    @(negedge mclk_in);
    chk(32'(dp), 32'h1);
    @(posedge mclk_in);
    tp <= 0;
    tclk <= 1;
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      rx_mark(r[0]);
    end
    rd(OFF_IRQ_STAT, v, resp);
    chk(v, 32'h1 << EV_MARK);
    wr(OFF_IRQ_STAT, 32'h7, resp);
    // line loopback: recovered data and clock drive the line, slow pulse
    line_n <= 0;
    width <= 6'd30;
    rd(OFF_STAT, v, resp);
    chk(v & 32'hd, 32'h1 << STAT_LINE_LB);
    seen = 0;
    pol <= 1;
    send <= 1;
    @(posedge mclk_in);
    send <= 0;
    repeat (100) begin
      @(negedge mclk_in);
      chk(32'({dp, dn}), 32'({!rclk & rxp & !rxn, !rclk & rxn & !rxp}));
      seen = seen | dp;
    end
    chk(32'(seen), 32'h1);
    @(posedge mclk_in);
    line_n <= 1;
    wr(OFF_IRQ_STAT, 32'h7, resp);
    // threshold boundary: equal is kept, one below is lost
    for (int i = 0; i < 5; i++) begin
      peak <= pk[i];
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      chk(32'(los), 32'(pl[i]));
      @(posedge mclk_in);
    end
    rd(OFF_IRQ_STAT, v, resp);
    chk(v, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1, resp);
    @(negedge mclk_in);
    chk(32'(irq), 32'h1);
    wr(OFF_IRQ_STAT, 32'h1, resp);
    @(negedge mclk_in);
    chk(32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h2, resp);
    @(negedge mclk_in);
    chk(32'(irq), 32'h1);
    wr(OFF_LOS_THR, 32'h20, resp);
    peak <= 8'h30;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    chk(32'(los), 32'h0);
    // unmasked loss of signal must raise the interrupt with the flag
    wr(OFF_IRQ_MASK, 32'h1, resp);
    peak <= 8'h10;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    chk(32'({los, irq}), 32'h3);
    tally_and_finish();
  end
endmodule
